// >>> shared/tmps_regs.vh
// Register map and field layout of the test-mode and pattern-select block.
// Assumes a 10-bit control data port with separate address and data cycles.
`ifndef TMPS_REGS_VH
`define TMPS_REGS_VH

// ==========================================================
// Addresses
`define TMPS_ADDR_W 10
`define TMPS_ADDR_TEST_SELECT 10'h00D
`define TMPS_ADDR_TEST_PATH_ENABLES 10'h055

// ==========================================================
// Test path enable fields
`define TMPS_EN_SCRAMBLE 0
`define TMPS_EN_LEVEL_CODE 1
`define TMPS_EN_LOW_CLIP 2
`define TMPS_EN_TRS_DETECT 3
`define TMPS_EN_W 4
`define TMPS_EN_RESET 4'hF

// ==========================================================
// Test select register fields
`define TMPS_SEL_MSB 5
`define TMPS_SEL_W 6
`define TMPS_SEL_RESET 6'h00
`define TMPS_SEL_RESULT 6
`define TMPS_SEL_GEN_ON 7

// ==========================================================
// Select word fields
`define TMPS_SW_HD 5
`define TMPS_SW_PROG 4
`define TMPS_SW_SUB_HI 3
`define TMPS_SW_SUB_LO 2
`define TMPS_SW_KIND_HI 1
`define TMPS_SW_KIND_LO 0

// ==========================================================
// Pattern kinds
`define TMPS_KIND_BLACK 2'h0
`define TMPS_KIND_PLL_PATH 2'h1
`define TMPS_KIND_EQ_PATH 2'h2
`define TMPS_KIND_BARS 2'h3

// ==========================================================
// Decoded raster formats
`define TMPS_FMT_W 4
`define TMPS_FMT_HD_I30_260 4'h0
`define TMPS_FMT_HD_I30_274 4'h1
`define TMPS_FMT_HD_I25_274 4'h2
`define TMPS_FMT_HD_I25_295 4'h3
`define TMPS_FMT_HD_P30 4'h4
`define TMPS_FMT_HD_P25 4'h5
`define TMPS_FMT_HD_P24 4'h6
`define TMPS_FMT_HD_P60_750 4'h7
`define TMPS_FMT_SD_NTSC_27 4'h8
`define TMPS_FMT_SD_PAL_27 4'h9
`define TMPS_FMT_SD_NTSC_36 4'hA
`define TMPS_FMT_SD_PAL_36 4'hB
`define TMPS_FMT_SD_NTSC_54 4'hC
`define TMPS_FMT_SD_PAL_54 4'hD
`define TMPS_FMT_NONE 4'hF

// SD self-check words: NTSC 4x3 bars and PAL 4x3 PLL pathological
`define TMPS_SD_BUILT_IN_SELF_CHECK_NTSC 6'h03
`define TMPS_SD_BUILT_IN_SELF_CHECK_PAL 6'h11

`endif

// >>> hdl/tmps_pattern_decode.v
// Decoder of the six-bit test pattern select word.
// Pure combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
`default_nettype none
`include "tmps_regs.vh"

module tmps_pattern_decode (
  // Select word
  input wire [`TMPS_SEL_W-1:0] selWord,
  // Decoded fields
  output wire isHd,
  output wire isProgOrPal,
  output wire [1:0] patternKind,
  output reg [`TMPS_FMT_W-1:0] rasterFormat,
  output wire formatValid,
  output wire isSelfCheckPattern
);

  wire [1:0] subSel;

  assign isHd = selWord[`TMPS_SW_HD]; // RQ7
  assign isProgOrPal = selWord[`TMPS_SW_PROG]; // RQ7
  assign patternKind = selWord[`TMPS_SW_KIND_HI:`TMPS_SW_KIND_LO]; // RQ7
  assign subSel = selWord[`TMPS_SW_SUB_HI:`TMPS_SW_SUB_LO];

  // ==========================================================
  // Raster format
  always @* begin
    rasterFormat = `TMPS_FMT_NONE;
    case ({isHd, isProgOrPal, subSel})
      4'h8: rasterFormat = `TMPS_FMT_HD_I30_260; // RQ10
      4'h9: rasterFormat = `TMPS_FMT_HD_I30_274; // RQ10
      4'hA: rasterFormat = `TMPS_FMT_HD_I25_274; // RQ10
      4'hB: rasterFormat = `TMPS_FMT_HD_I25_295; // RQ10
      4'hC: rasterFormat = `TMPS_FMT_HD_P30; // RQ10
      4'hD: rasterFormat = `TMPS_FMT_HD_P25; // RQ10
      4'hE: rasterFormat = `TMPS_FMT_HD_P24;
      4'hF: rasterFormat = `TMPS_FMT_HD_P60_750;
      4'h0: rasterFormat = `TMPS_FMT_SD_NTSC_27;
      4'h4: rasterFormat = `TMPS_FMT_SD_PAL_27;
      4'h1: rasterFormat = `TMPS_FMT_SD_NTSC_36;
      4'h5: rasterFormat = `TMPS_FMT_SD_PAL_36;
      4'h2: rasterFormat = `TMPS_FMT_SD_NTSC_54;
      4'h6: rasterFormat = `TMPS_FMT_SD_PAL_54;
      default: rasterFormat = `TMPS_FMT_NONE;
    endcase
  end

  assign formatValid = (rasterFormat != `TMPS_FMT_NONE);

  // ==========================================================
  // Self-check data: every HD bars pattern, two SD words only
  assign isSelfCheckPattern = isHd
    ? (formatValid && patternKind == `TMPS_KIND_BARS) // RQ9
    : (selWord == `TMPS_SD_BUILT_IN_SELF_CHECK_NTSC || selWord == `TMPS_SD_BUILT_IN_SELF_CHECK_PAL); // RQ8

endmodule
`default_nettype wire

// >>> hdl/tmps_test_ctrl.v
// Test-mode path enables and test pattern select registers, reached over
// the ancillary/control data port. All port pins are asynchronous to clk
// and are synchronised here; the port clock must be slow against clk.
//
// Notes on behaviour
// RQ1 - Reading the path enable register turns all four enables back on.
// RQ2 - Writing the path enable register sets each enable from its data bit.
// RQ3 - Scramble enable on means scrambling applies; off bypasses; default on.
// RQ4 - Level transition enable on means NRZ to NRZI conversion; default on.
// RQ5 - Low-bit clip enable on means LSB clipping of video; default on.
// RQ6 - Timing reference detect enable on runs the detector; default on.
// RQ7 - Select bit 5 HD/SD, bit 4 progressive-PAL/interlaced-NTSC, bits 1:0 kind.
// RQ8 - SD self-check uses only NTSC 4x3 bars or PAL 4x3 PLL pathological.
// RQ9 - HD self-check treats bars of every supported format as check data.
// RQ10 - HD bits 3:2 choose among the 1125-line and progressive formats.
// RQ11 - Pattern generator on enables generator and self-check with chosen pattern.
// RQ12 - Self-check result bit reads one on pass, zero otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "tmps_regs.vh"

module tmps_test_ctrl #(
  parameter AD_W = 10
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control data port pins
  input wire portClk,
  input wire ancCtrlSel,
  input wire rdWrSel,
  input wire [AD_W-1:0] adIn,
  output wire [AD_W-1:0] adOut,
  output wire adOe,
  // Path enables to the datapath
  output wire scrambleOn,
  output wire levelCodeOn,
  output wire lowClipOn,
  output wire trsDetectOn,
  // Pattern generator control
  output wire patternGenOn,
  output wire selfCheckOn,
  output wire [`TMPS_SEL_W-1:0] patternSelect,
  output wire [1:0] patternKind,
  output wire [`TMPS_FMT_W-1:0] rasterFormat,
  output wire patternIsHd,
  output wire patternProgOrPal,
  output wire patternUsable,
  // Self-check outcome from the checker, same clock
  input wire checkDone,
  input wire checkPass
);

  // ==========================================================
  // Pin synchronisers
  reg [2:0] pclkSync_ff;
  reg [1:0] selSync_ff;
  reg [1:0] rwSync_ff;
  reg [AD_W-1:0] adMeta_ff;
  reg [AD_W-1:0] adSync_ff;

  always @(posedge clk) begin
    if (srst) begin
      pclkSync_ff <= 3'h0;
      selSync_ff <= 2'h3;
      rwSync_ff <= 2'h3;
      adMeta_ff <= {AD_W{1'b0}};
      adSync_ff <= {AD_W{1'b0}};
    end else begin
      pclkSync_ff <= {pclkSync_ff[1:0], portClk};
      selSync_ff <= {selSync_ff[0], ancCtrlSel};
      rwSync_ff <= {rwSync_ff[0], rdWrSel};
      adMeta_ff <= adIn;
      adSync_ff <= adMeta_ff;
    end
  end

  wire ctrlSelected;
  wire readSel;
  wire portEdge;

  // Edge taken between second and third stages only
  assign portEdge = pclkSync_ff[1] & ~pclkSync_ff[2];
  // Control registers addressed while the select pin is low
  assign ctrlSelected = ~selSync_ff[1];
  assign readSel = rwSync_ff[1];

  // ==========================================================
  // Address / data phase tracking
  reg dataPhase_ff;
  reg nxt_dataPhase;
  reg [AD_W-1:0] addr_ff;
  reg [AD_W-1:0] nxt_addr;

  always @* begin
    nxt_dataPhase = dataPhase_ff;
    nxt_addr = addr_ff;
    if (!ctrlSelected) begin
      nxt_dataPhase = 1'b0;
    end else if (portEdge) begin
      if (!dataPhase_ff) begin
        nxt_addr = adSync_ff;
      end
      nxt_dataPhase = ~dataPhase_ff;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      dataPhase_ff <= 1'b0;
      addr_ff <= {AD_W{1'b0}};
    end else begin
      dataPhase_ff <= nxt_dataPhase;
      addr_ff <= nxt_addr;
    end
  end

  wire dataEdge;
  wire wrStrobe;
  wire rdStrobe;
  wire hitEnables;
  wire hitSelect;

  assign dataEdge = ctrlSelected & portEdge & dataPhase_ff;
  assign wrStrobe = dataEdge & ~readSel;
  assign rdStrobe = dataEdge & readSel;
  assign hitEnables = (addr_ff == `TMPS_ADDR_TEST_PATH_ENABLES);
  assign hitSelect = (addr_ff == `TMPS_ADDR_TEST_SELECT);

  // ==========================================================
  // Registers
  reg [`TMPS_EN_W-1:0] pathEn_ff;
  reg [`TMPS_EN_W-1:0] nxt_pathEn;
  reg [`TMPS_SEL_W-1:0] select_ff;
  reg [`TMPS_SEL_W-1:0] nxt_select;
  reg genOn_ff;
  reg nxt_genOn;
  reg result_ff;
  reg nxt_result;

  always @* begin
    nxt_pathEn = pathEn_ff;
    nxt_select = select_ff;
    nxt_genOn = genOn_ff;
    if (wrStrobe && hitEnables) begin
      nxt_pathEn = adSync_ff[`TMPS_EN_W-1:0]; // RQ2
    end else if (rdStrobe && hitEnables) begin
      // Read hands out the old value, then restores defaults
      nxt_pathEn = `TMPS_EN_RESET; // RQ1
    end
    if (wrStrobe && hitSelect) begin
      nxt_select = adSync_ff[`TMPS_SEL_MSB:0];
      nxt_genOn = adSync_ff[`TMPS_SEL_GEN_ON]; // RQ11
    end
  end

  wire patternOk;

  // Result only meaningful for a check pattern while checking runs
  always @* begin
    nxt_result = result_ff;
    if (!genOn_ff || !patternOk) begin
      nxt_result = 1'b0; // RQ12
    end else if (checkDone) begin
      nxt_result = checkPass; // RQ12
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pathEn_ff <= `TMPS_EN_RESET;
      select_ff <= `TMPS_SEL_RESET;
      genOn_ff <= 1'b0;
      result_ff <= 1'b0;
    end else begin
      pathEn_ff <= nxt_pathEn;
      select_ff <= nxt_select;
      genOn_ff <= nxt_genOn;
      result_ff <= nxt_result;
    end
  end

  // ==========================================================
  // Read data: driven from the read edge until the next port edge or until deselected
  reg [AD_W-1:0] rdData_ff;
  reg [AD_W-1:0] nxt_rdData;
  reg rdOe_ff;
  reg nxt_rdOe;

  always @* begin
    nxt_rdData = rdData_ff;
    nxt_rdOe = rdOe_ff;
    if (!ctrlSelected) begin
      nxt_rdOe = 1'b0;
    end else if (rdStrobe) begin
      nxt_rdOe = 1'b1;
      nxt_rdData = {AD_W{1'b0}};
      if (hitEnables) begin
        nxt_rdData[`TMPS_EN_W-1:0] = pathEn_ff;
      end else if (hitSelect) begin
        nxt_rdData[`TMPS_SEL_MSB:0] = select_ff;
        nxt_rdData[`TMPS_SEL_RESULT] = result_ff;
        nxt_rdData[`TMPS_SEL_GEN_ON] = genOn_ff;
      end
    end else if (portEdge) begin
      nxt_rdOe = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rdData_ff <= {AD_W{1'b0}};
      rdOe_ff <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdOe_ff <= nxt_rdOe;
    end
  end

  assign adOut = rdData_ff;
  assign adOe = rdOe_ff;

  // ==========================================================
  // Pattern select decode
  tmps_pattern_decode u_decode (
    .selWord(select_ff),
    .isHd(patternIsHd),
    .isProgOrPal(patternProgOrPal),
    .patternKind(patternKind),
    .rasterFormat(rasterFormat),
    .formatValid(),
    .isSelfCheckPattern(patternOk)
  );

  // ==========================================================
  // Outputs to the datapath
  assign scrambleOn = pathEn_ff[`TMPS_EN_SCRAMBLE]; // RQ3
  assign levelCodeOn = pathEn_ff[`TMPS_EN_LEVEL_CODE]; // RQ4
  assign lowClipOn = pathEn_ff[`TMPS_EN_LOW_CLIP]; // RQ5
  assign trsDetectOn = pathEn_ff[`TMPS_EN_TRS_DETECT]; // RQ6
  assign patternGenOn = genOn_ff; // RQ11
  // Self-check runs only on a word that counts as check data
  assign selfCheckOn = genOn_ff & patternOk; // RQ8 RQ9 RQ11
  assign patternSelect = select_ff;
  assign patternUsable = patternOk;

endmodule
`default_nettype wire

// >>> verification/tmps_test_ctrl_properties.sv
// Port checker of the test control block, bound to every tmps_test_ctrl.
// Assumes host pins hold at least 4 clk around each portClk rise.
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module tmps_test_ctrl_checker #(
  parameter AD_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Port pins
  input wire logic portClk,
  input wire logic ancCtrlSel,
  input wire logic rdWrSel,
  input wire logic [AD_W-1:0] adIn,
  input wire logic [AD_W-1:0] adOut,
  input wire logic adOe,
  // Path enables
  input wire logic scrambleOn,
  input wire logic levelCodeOn,
  input wire logic lowClipOn,
  input wire logic trsDetectOn,
  // Pattern control
  input wire logic patternGenOn,
  input wire logic selfCheckOn,
  input wire logic [5:0] patternSelect,
  input wire logic [1:0] patternKind,
  input wire logic [3:0] rasterFormat,
  input wire logic patternIsHd,
  input wire logic patternProgOrPal,
  input wire logic patternUsable,
  input wire logic checkDone,
  input wire logic checkPass
);
  wire [3:0] en = {trsDetectOn, lowClipOn, levelCodeOn, scrambleOn};
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_all_on: assert property (
    $fell(srst) |-> en == 4'hF && !patternGenOn && !adOe) else $error("bad reset state");
  // Pins are sampled four edges before the enables move
  a_read_restores: assert property (
    $changed(en) && $past(rdWrSel, 4) |-> en == 4'hF) else $error("read left enable off");
  a_only_write_clears: assert property (
    |(~en & $past(en)) |-> !$past(rdWrSel, 4)) else $error("enable cleared by read");
  a_field_split: assert property (
    patternKind == patternSelect[1:0] && patternIsHd == patternSelect[5]
    && patternProgOrPal == patternSelect[4]) else $error("select fields wrong");
  a_hd_interlace: assert property (
    patternSelect[5:4] == 2'h2 |-> rasterFormat == {2'h0, patternSelect[3:2]})
    else $error("interlaced format wrong");
  a_hd_bars_check: assert property (
    patternSelect[5] && patternKind == 2'h3 |-> patternUsable) else $error("HD bars unusable");
  a_sd_check_words: assert property (
    patternUsable && !patternSelect[5] |-> patternSelect inside {6'h03, 6'h11})
    else $error("SD check word wrong");
  a_check_needs_gen: assert property (
    selfCheckOn == (patternGenOn && patternUsable)) else $error("self-check enable wrong");
  c_read: cover property ($rose(adOe));
  c_check: cover property (selfCheckOn);
  c_bypass: cover property (!scrambleOn && !trsDetectOn);
endmodule
bind tmps_test_ctrl tmps_test_ctrl_checker #(.AD_W(AD_W)) chk (.clk, .srst, .portClk,
  .ancCtrlSel, .rdWrSel, .adIn, .adOut, .adOe, .scrambleOn, .levelCodeOn, .lowClipOn,
  .trsDetectOn, .patternGenOn, .selfCheckOn, .patternSelect, .patternKind, .rasterFormat,
  .patternIsHd, .patternProgOrPal, .patternUsable, .checkDone, .checkPass);
`default_nettype wire

// >>> verification/tmps_test_ctrl_tb.sv
// Self-checking bench of the test control block over its control port.
// Assumes the checker file is compiled first and binds itself.
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module tmps_test_ctrl_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic portClk = 1'b0;
  logic ancCtrlSel = 1'b1;
  logic rdWrSel = 1'b1;
  logic [9:0] adIn = 10'h000;
  logic checkDone = 1'b0;
  logic checkPass = 1'b0;
  wire [9:0] adOut;
  wire adOe, scrambleOn, levelCodeOn, lowClipOn, trsDetectOn, patternGenOn, selfCheckOn;
  wire [5:0] patternSelect;
  wire [1:0] patternKind;
  wire [3:0] rasterFormat;
  wire patternIsHd, patternProgOrPal, patternUsable;
  wire [3:0] en = {trsDetectOn, lowClipOn, levelCodeOn, scrambleOn};
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [9:0] rdVal;
  always #4 clk = ~clk;
  tmps_test_ctrl #(.AD_W(10)) uut (.clk, .srst, .portClk, .ancCtrlSel, .rdWrSel, .adIn,
    .adOut, .adOe, .scrambleOn, .levelCodeOn, .lowClipOn, .trsDetectOn, .patternGenOn,
    .selfCheckOn, .patternSelect, .patternKind, .rasterFormat, .patternIsHd,
    .patternProgOrPal, .patternUsable, .checkDone, .checkPass);
  // ====
  // Helpers
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Pins settle 3 clk ahead and hold 8 clk after the rise, beyond the syncer window
  task automatic strobe(input logic rw, input logic [9:0] d);
    ancCtrlSel = 1'b0;
    rdWrSel = rw;
    adIn = d;
    tick(3);
    portClk = 1'b1;
    tick(5);
    portClk = 1'b0;
    tick(3);
  endtask
  task automatic wr(input logic [9:0] a, input logic [9:0] d);
    strobe(1'b0, a);
    strobe(1'b0, d);
    ancCtrlSel = 1'b1;
    tick(2);
  endtask
  task automatic rd(input logic [9:0] a);
    strobe(1'b0, a);
    strobe(1'b1, 10'h2AA);
    rdVal = adOe ? adOut : 10'h3FF;
    ancCtrlSel = 1'b1;
    tick(2);
  endtask
  function automatic logic [3:0] fmt(input logic [5:0] w);
    if (w[5]) return w[4] ? 4'h4 + w[3:2] : {2'h0, w[3:2]};
    if (w[3:2] == 2'h3) return 4'hF;
    return 4'h8 + {w[3:2], w[4]};
  endfunction
  // ====
  // Scenarios
  task automatic t_reset();
    chk({6'h00, en}, 10'h00F);
    chk({9'h000, patternGenOn}, 10'h000);
    rd(10'h00D);
    chk(rdVal, 10'h000);
  endtask
  task automatic t_write_bits();
    for (int i = 0; i < 4; i++) begin
      wr(10'h055, {6'h00, 4'hF ^ (4'h1 << i)});
      chk({6'h00, en}, {6'h00, 4'hF ^ (4'h1 << i)});
    end
  endtask
  task automatic t_read_restore();
    wr(10'h055, 10'h005);
    rd(10'h055);
    chk(rdVal, 10'h005);
    chk({6'h00, en}, 10'h00F);
    wr(10'h055, 10'h000);
    wr(10'h100, 10'h3FF);
    chk({6'h00, en}, 10'h000);
    rd(10'h100);
    chk(rdVal, 10'h000);
    chk({6'h00, en}, 10'h000);
    rd(10'h055);
    rd(10'h055);
    chk(rdVal, 10'h00F);
  endtask
  task automatic t_decode();
    logic [5:0] w;
    logic u;
    for (int i = 0; i < 64; i++) begin
      w = i[5:0];
      u = w[5] ? (w[1:0] == 2'h3) : (w == 6'h03 || w == 6'h11);
      wr(10'h00D, {4'h2, w});
      chk({4'h0, patternSelect}, {4'h0, w});
      chk({patternIsHd, patternProgOrPal, patternUsable, selfCheckOn, patternKind,
        rasterFormat}, {w[5], w[4], u, u, w[1:0], fmt(w)});
    end
  endtask
  task automatic pulse(input logic pass);
    checkPass = pass;
    checkDone = 1'b1;
    tick(1);
    checkDone = 1'b0;
    tick(1);
  endtask
  task automatic t_self_check();
    wr(10'h00D, 10'h083);
    chk({8'h00, patternGenOn, selfCheckOn}, 10'h003);
    pulse(1'b1);
    rd(10'h00D);
    chk(rdVal, 10'h0C3);
    pulse(1'b0);
    rd(10'h00D);
    chk(rdVal, 10'h083);
    wr(10'h00D, 10'h003);
    chk({8'h00, patternGenOn, selfCheckOn}, 10'h000);
    pulse(1'b1);
    rd(10'h00D);
    chk(rdVal, 10'h003);
  endtask
  initial begin
    tick(12);
    srst = 1'b0;
    tick(4);
    t_reset();
    t_write_bits();
    t_read_restore();
    t_decode();
    t_self_check();
    report_and_stop();
  end
endmodule
`default_nettype wire
